// file: common/des_defines.svh
// Constants of the transfer event selector: addresses, fields, codes, reset values
`ifndef DES_DEFINES_SVH
`define DES_DEFINES_SVH

// ****************************************
// Register addresses
// ****************************************
`define DES_ADDR_A        32'h01a0ff00
`define DES_ADDR_B        32'h01a0ff04
`define DES_ADDR_D        32'h01a0ff0c

// ****************************************
// Field layout
// ****************************************
`define DES_CODE_W        6
`define DES_FIELD_PITCH   8
`define DES_FIELDS_PER_REG 4
`define DES_NUM_SEL       12
`define DES_NUM_CHAN      16
`define DES_CHAIN_LO      8
`define DES_CHAIN_N       4
`define DES_RSVD_MASK     32'hc0c0c0c0

// ****************************************
// Event codes
// ****************************************
`define DES_CODE_NONE     6'h00
`define DES_CODE_TIMER0   6'h01
`define DES_CODE_TIMER1   6'h02
`define DES_CODE_MEMIF    6'h03
`define DES_CODE_GP4      6'h04
`define DES_CODE_GP7      6'h07
`define DES_CODE_GP2      6'h0a
`define DES_CODE_P0_TX    6'h0c
`define DES_CODE_P1_RX    6'h0f
`define DES_CODE_LIMIT    6'h10

// ****************************************
// Reset codes: channels 0..7 take their own number, 12..15 take 0x0c..0x0f
// ****************************************
`define DES_RST_LOW_BASE  6'h00
`define DES_RST_HIGH_BASE 6'h0c

// ****************************************
// Bus constants
// ****************************************
`define DES_HTRANS_ACT_BIT 1
`define DES_HSIZE_WORD    3'h2

`endif

// file: common/des_pkg.sv
// Types shared by the transfer event selector
package des_pkg;
  typedef logic [5:0] des_code_t;
  typedef logic [1:0] des_regsel_t;
  typedef enum logic [1:0] {
    DES_ST_IDLE  = 2'b01,
    DES_ST_WDATA = 2'b10
  } des_state_e;
endpackage : des_pkg

// file: design/des_route_mux.sv
// Selects one routed event for a single channel from its event code
`timescale 1ns/1ns
`default_nettype none
`include "des_defines.svh"
module des_route_mux (
  input  wire des_pkg::des_code_t code_i,
  input  wire logic [15:0]        events_i,
  output logic                    hit_o
);
  import des_pkg::*;

  // Codes at or above the limit select nothing; reserved slots of events_i are zero
  always_comb begin
    if (code_i >= `DES_CODE_LIMIT) begin
      hit_o = 1'b0;
    end else begin
      hit_o = events_i[code_i[3:0]];
    end
  end
endmodule : des_route_mux
`default_nettype wire

// file: design/des_event_selector.sv
// Transfer event selector: AHB-Lite registers and event routing to 16 channels
//
// Overview of operation
// - There are 16 channels and channels 8 to 11 only follow chaining completion codes.
// - The other 12 channels are each triggered by the event their own field selects.
// - A 6-bit code written to a field by a word write makes that channel follow the matching event.
// - Three registers hold channels 0-3, 4-7 and 12-15; chaining channels have none.
// - Fields sit at bits 5:0, 13:8, 21:16 and 29:24, lowest channel in lowest field.
// - Codes 1, 2 and 3 select timer 0, timer 1 and the memory interface events.
// - Codes 4 to 7 select pins 4 to 7 and code 10 selects the pin 2 event.
// - After reset channels 0 to 7 hold their own channel number as code.
// - After reset channels 12 to 15 hold codes 12 to 15, the serial port events.
// - Reserved bits above each field read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
`include "des_defines.svh"
module des_event_selector #(
  parameter int CODE_W = `DES_CODE_W
) (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        timer0_event_i,
  input  wire logic        timer1_event_i,
  input  wire logic        memif_event_i,
  input  wire logic        gp_pin2_event_i,
  input  wire logic        gp_pin4_event_i,
  input  wire logic        gp_pin5_event_i,
  input  wire logic        gp_pin6_event_i,
  input  wire logic        gp_pin7_event_i,
  input  wire logic        port0_tx_event_i,
  input  wire logic        port0_rx_event_i,
  input  wire logic        port1_tx_event_i,
  input  wire logic        port1_rx_event_i,
  input  wire logic [3:0]  chain_completion_code_i,
  output logic [15:0]      chan_trigger_o
);
  import des_pkg::*;

  // ****************************************
  // Elaboration check
  // ****************************************
  if (CODE_W != `DES_CODE_W) begin : g_bad_width
    $error("des_event_selector: code width must be six");
  end

  // ****************************************
  // Helper functions
  // ****************************************
  // Extracts field k of a register word
  function automatic des_code_t get_field(input logic [31:0] word, input int k);
    get_field = word[k*`DES_FIELD_PITCH +: `DES_CODE_W];
  endfunction : get_field

  // Builds a register word from four codes, reserved gaps zero
  function automatic logic [31:0] pack_word(input des_code_t c0, input des_code_t c1,
                                            input des_code_t c2, input des_code_t c3);
    pack_word = {2'h0, c3, 2'h0, c2, 2'h0, c1, 2'h0, c0};
  endfunction : pack_word

  // ****************************************
  // State
  // ****************************************
  des_code_t   code_reg [`DES_NUM_SEL];
  des_code_t   code_next [`DES_NUM_SEL];
  des_state_e  state_reg;
  des_state_e  state_next;
  des_regsel_t wsel_reg;
  des_regsel_t wsel_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic [15:0] trig_reg;
  logic [15:0] trig_next;
  logic [15:0] ev_vec;
  logic [`DES_NUM_SEL-1:0] hit;
  logic        acc;
  logic        hit_a;
  logic        hit_b;
  logic        hit_d;
  logic        mapped;

  // ****************************************
  // Address phase decode
  // ****************************************
  // A transfer is taken when selected, active and the bus is ready
  assign acc    = hsel_i && hready_i && htrans_i[`DES_HTRANS_ACT_BIT];
  assign hit_a  = (haddr_i == `DES_ADDR_A);
  assign hit_b  = (haddr_i == `DES_ADDR_B);
  assign hit_d  = (haddr_i == `DES_ADDR_D);
  assign mapped = hit_a || hit_b || hit_d;

  // Bus state: a word write to a mapped register opens a write data phase
  always_comb begin
    state_next = DES_ST_IDLE;
    wsel_next  = 2'h0;
    if (acc && hwrite_i && mapped && (hsize_i == `DES_HSIZE_WORD)) begin
      state_next = DES_ST_WDATA;
      if (hit_a) begin
        wsel_next = 2'h0;
      end else if (hit_b) begin
        wsel_next = 2'h1;
      end else begin
        wsel_next = 2'h2;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= DES_ST_IDLE;
      wsel_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      wsel_reg  <= wsel_next;
    end
  end

  // ****************************************
  // Selector fields
  // ****************************************
  // Write data phase stores the four fields; gap bits are dropped
  always_comb begin
    for (int i = 0; i < `DES_NUM_SEL; i++) begin
      code_next[i] = code_reg[i];
    end
    case (state_reg)
      DES_ST_WDATA: begin
        for (int k = 0; k < `DES_FIELDS_PER_REG; k++) begin
          code_next[wsel_reg*`DES_FIELDS_PER_REG + k] = get_field(hwdata_i, k);
        end
      end
      default: begin
      end
    endcase
  end

  // Reset codes: low block numbered by channel, high block the serial port events
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < `DES_CHAIN_LO; i++) begin
        code_reg[i] <= `DES_RST_LOW_BASE + 6'(i);
      end
      for (int i = 0; i < `DES_CHAIN_N; i++) begin
        code_reg[`DES_CHAIN_LO + i] <= `DES_RST_HIGH_BASE + 6'(i);
      end
    end else begin
      for (int i = 0; i < `DES_NUM_SEL; i++) begin
        code_reg[i] <= code_next[i];
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Read from next values so a write just before a read is seen
  always_comb begin
    hrdata_next = 32'h0;
    if (acc && !hwrite_i) begin
      if (hit_a) begin
        hrdata_next = pack_word(code_next[0], code_next[1], code_next[2], code_next[3]);
      end else if (hit_b) begin
        hrdata_next = pack_word(code_next[4], code_next[5], code_next[6], code_next[7]);
      end else if (hit_d) begin
        hrdata_next = pack_word(code_next[8], code_next[9], code_next[10], code_next[11]);
      end else begin
        hrdata_next = 32'h0; // Unmapped reads zero
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_reg <= 32'h0;
    end else begin
      hrdata_reg <= hrdata_next;
    end
  end

  // ****************************************
  // Event routing
  // ****************************************
  // Event vector indexed by code; reserved codes hold zero
  always_comb begin
    ev_vec     = 16'h0;
    ev_vec[1]  = timer0_event_i;
    ev_vec[2]  = timer1_event_i;
    ev_vec[3]  = memif_event_i;
    ev_vec[4]  = gp_pin4_event_i;
    ev_vec[5]  = gp_pin5_event_i;
    ev_vec[6]  = gp_pin6_event_i;
    ev_vec[7]  = gp_pin7_event_i;
    ev_vec[10] = gp_pin2_event_i;
    ev_vec[12] = port0_tx_event_i;
    ev_vec[13] = port0_rx_event_i;
    ev_vec[14] = port1_tx_event_i;
    ev_vec[15] = port1_rx_event_i;
  end

  // One selector per programmable channel
  for (genvar g = 0; g < `DES_NUM_SEL; g++) begin : g_route
    des_route_mux u_mux (
      .code_i   (code_reg[g]),
      .events_i (ev_vec),
      .hit_o    (hit[g])
    );
  end

  // Channel triggers: chaining channels pass completion codes straight on
  always_comb begin
    trig_next = 16'h0;
    trig_next[`DES_CHAIN_LO-1:0] = hit[`DES_CHAIN_LO-1:0];
    trig_next[`DES_CHAIN_LO +: `DES_CHAIN_N] = chain_completion_code_i;
    trig_next[`DES_NUM_CHAN-1 -: `DES_CHAIN_N] = hit[`DES_NUM_SEL-1 -: `DES_CHAIN_N];
  end

  // Registered triggers follow the current code only, so a change adds no pulse
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_reg <= 16'h0;
    end else begin
      trig_reg <= trig_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1; // Zero wait states
      hresp_o     <= 1'b0; // Always OKAY
    end
  end

  assign hrdata_o       = hrdata_reg;
  assign chan_trigger_o = trig_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  logic rst_seen_reg;
  logic sel1_live;

  // Channel 1 has a live event behind its current code
  assign sel1_live = (code_reg[1] < `DES_CODE_LIMIT) && ev_vec[code_reg[1][3:0]];

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_seen_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
    end
  end

  AST_CHAIN_PASS: assert property (
    rst_seen_reg |-> chan_trigger_o[11:8] == $past(chain_completion_code_i))
    else $error("chaining channel does not follow completion code");

  AST_CH12_ROUTE: assert property (
    (code_reg[8] == `DES_CODE_P0_TX && port0_tx_event_i) |=> chan_trigger_o[12])
    else $error("channel 12 missed its routed event");

  AST_WRITE_TAKES: assert property (
    (acc && hwrite_i && hit_b && hsize_i == `DES_HSIZE_WORD) ##1 1'b1
      |=> code_reg[5] == $past(hwdata_i[13:8]))
    else $error("written code not stored");

  AST_UNMAPPED_ZERO: assert property (
    (acc && !hwrite_i && !mapped) |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");

  AST_FIELD_READ: assert property (
    (acc && !hwrite_i && hit_d && state_reg == DES_ST_IDLE)
      |=> hrdata_o[29:24] == code_reg[11] && hrdata_o[5:0] == code_reg[8])
    else $error("read field placement wrong");

  AST_TIMER1_ROUTE: assert property (
    (code_reg[2] == `DES_CODE_TIMER1 && timer1_event_i) |=> chan_trigger_o[2])
    else $error("timer 1 event not routed");

  AST_GP2_ROUTE: assert property (
    (code_reg[11] == `DES_CODE_GP2 && gp_pin2_event_i) |=> chan_trigger_o[15])
    else $error("pin 2 event not routed");

  AST_RESET_LOW: assert property (
    !rst_seen_reg |-> code_reg[0] == `DES_CODE_NONE && code_reg[7] == `DES_CODE_GP7)
    else $error("low channel reset code wrong");

  AST_RESET_HIGH: assert property (
    !rst_seen_reg |-> code_reg[8] == `DES_CODE_P0_TX && code_reg[11] == `DES_CODE_P1_RX)
    else $error("high channel reset code wrong");

  AST_RSVD_ZERO: assert property (
    (hrdata_o & `DES_RSVD_MASK) == 32'h0)
    else $error("reserved bits read non-zero");

  AST_RSVD_QUIET: assert property (
    (code_reg[3] >= `DES_CODE_LIMIT || code_reg[3] == `DES_CODE_NONE) |=> !chan_trigger_o[3])
    else $error("reserved code produced a trigger");

  AST_NO_EXTRA: assert property (
    chan_trigger_o[1] |-> $past(sel1_live))
    else $error("trigger without a selected event");

  CVR_WRITE_READ: cover property (
    (acc && hwrite_i && hit_a) ##2 (acc && !hwrite_i && hit_a));
  CVR_REROUTE: cover property (
    (code_reg[4] == `DES_CODE_GP4) ##[1:20] (code_reg[4] == `DES_CODE_TIMER0 && chan_trigger_o[4]));
  CVR_CHAIN: cover property (chan_trigger_o[9]);
  CVR_UNMAPPED: cover property (acc && !mapped);
endmodule : des_event_selector
`default_nettype wire

// file: tb/des_event_src.sv
// Event source model: turns one-cycle fire requests into event pulses
`timescale 1ns/1ns
`default_nettype none
module des_event_src (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic [19:0] fire_i,
  output logic [15:0]      ev_o,
  output logic [3:0]       chain_o
);
  // ****************************************
  // Pulses launched just after the request edge, one cycle long
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_o    <= 16'h0000;
      chain_o <= 4'h0;
    end else begin
      ev_o    <= fire_i[15:0];  // Indexed by event code
      chain_o <= fire_i[19:16]; // Completion codes of channels 8..11
    end
  end
endmodule : des_event_src
`default_nettype wire

// file: tb/des_event_selector_tb.sv
// Self-checking bench of the transfer event selector
`timescale 1ns/1ns
`default_nettype none
`include "des_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module des_event_selector_tb;
  // Codes that select a real event
  localparam logic [15:0] VALID = 16'hf4fe;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        hsel      = 1'b0;
  logic        hwrite    = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [31:0] hwdata    = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic [2:0]  hsize     = 3'h0;
  logic [19:0] fire      = 20'h0;
  logic [31:0] rd_q;
  logic        rdy_q;
  logic        resp_q;
  logic [5:0]  sh [16];
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [15:0] ev;
  wire  [3:0]  chain;
  wire  [15:0] trig;
  int          error_cnt = 0;
  int          compares  = 0;

  // ****************************************
  // Clock, bus sampling, design and event model
  // ****************************************
  always #5 clk_sys_i = ~clk_sys_i;

  // Values the master takes at each rising edge
  always @(posedge clk_sys_i) begin
    rd_q  <= hrdata;
    rdy_q <= hreadyout;
    resp_q <= hresp;
  end

  des_event_selector dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .timer0_event_i(ev[1]), .timer1_event_i(ev[2]), .memif_event_i(ev[3]),
    .gp_pin2_event_i(ev[10]), .gp_pin4_event_i(ev[4]), .gp_pin5_event_i(ev[5]),
    .gp_pin6_event_i(ev[6]), .gp_pin7_event_i(ev[7]), .port0_tx_event_i(ev[12]),
    .port0_rx_event_i(ev[13]), .port1_tx_event_i(ev[14]), .port1_rx_event_i(ev[15]),
    .chain_completion_code_i(chain), .chan_trigger_o(trig)
  );

  des_event_src src (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .fire_i(fire), .ev_o(ev), .chain_o(chain)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // Waits for the edge at which hready is seen high
  task automatic wait_rdy();
    do begin
      @(posedge clk_sys_i);
      #1;
    end while (rdy_q !== 1'b1);
  endtask : wait_rdy

  // One single transfer; the shadow follows every write that must land
  task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] sz,
                     input logic [31:0] d, output logic [31:0] r);
    int base;
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= sz;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = rd_q;
    `CHK(resp_q, 1'b0)
    base = (a == `DES_ADDR_A) ? 0 : (a == `DES_ADDR_B) ? 4 : (a == `DES_ADDR_D) ? 12 : -1;
    if (w && sz == `DES_HSIZE_WORD && base >= 0) begin
      for (int i = 0; i < 4; i++) sh[base + i] = d[8 * i +: 6];
    end
  endtask : bus

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, `DES_HSIZE_WORD, 32'h0, r);
    `CHK(r, e)
  endtask : rdchk

  task automatic wr(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, sz, d, r);
  endtask : wr

  // Fires a set of events and compares the one-cycle triggers with the shadow
  task automatic route(input logic [19:0] f);
    logic [15:0] e;
    e = 16'h0000;
    for (int ch = 0; ch < 16; ch++) begin
      if (ch >= 8 && ch < 12) e[ch] = f[8 + ch];
      else e[ch] = (sh[ch] < 6'h10) && VALID[sh[ch][3:0]] && f[sh[ch][3:0]];
    end
    @(posedge clk_sys_i);
    fire <= f;
    @(posedge clk_sys_i);
    fire <= 20'h0;
    @(posedge clk_sys_i);
    #1;
    `CHK(trig, e)
    @(posedge clk_sys_i);
    #1;
    `CHK(trig, 16'h0000)
  endtask : route

  // ****************************************
  // Watchdog and test sequence
  // ****************************************
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end

  initial begin
    for (int ch = 0; ch < 16; ch++) sh[ch] = ch[5:0];
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    rdchk(`DES_ADDR_A, 32'h03020100);
    rdchk(`DES_ADDR_B, 32'h07060504);
    rdchk(`DES_ADDR_D, 32'h0f0e0d0c);
    rdchk(32'h01a0ff08, 32'h00000000);
    for (int c = 0; c < 16; c++) route(20'h1 << c);
    route(20'hf0000);
    route(20'h50002);
    wr(`DES_ADDR_A, `DES_HSIZE_WORD, 32'hffffffff);
    rdchk(`DES_ADDR_A, 32'h3f3f3f3f);
    route(20'h0ffff);
    wr(`DES_ADDR_D, `DES_HSIZE_WORD, 32'h0a010403);
    rdchk(`DES_ADDR_D, 32'h0a010403);
    for (int c = 1; c < 16; c++) route(20'h1 << c);
    wr(`DES_ADDR_B, `DES_HSIZE_WORD, 32'hc1c9c8c1);
    rdchk(`DES_ADDR_B, 32'h01090801);
    route(20'h00302);
    wr(`DES_ADDR_B, 3'h0, 32'h0f0f0f0f);
    rdchk(`DES_ADDR_B, 32'h01090801);
    wr(32'h01a0ff08, `DES_HSIZE_WORD, 32'h0c0c0c0c);
    rdchk(32'h01a0ff08, 32'h00000000);
    rdchk(`DES_ADDR_A, 32'h3f3f3f3f);
    rdchk(`DES_ADDR_D, 32'h0a010403);
    // Reset in mid-run brings back the reset codes
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (int ch = 0; ch < 16; ch++) sh[ch] = ch[5:0];
    @(posedge clk_sys_i);
    #1;
    rdchk(`DES_ADDR_A, 32'h03020100);
    rdchk(`DES_ADDR_B, 32'h07060504);
    rdchk(`DES_ADDR_D, 32'h0f0e0d0c);
    route(20'h01006);
    final_report();
  end
endmodule : des_event_selector_tb
`default_nettype wire
